// File: hw/eag_defs.svh
/*
 Constants of the effective address generator: register offsets, field
 positions, reset values and range limits. Assumes a 32-bit register port
 with a 4-bit word address and word-wide pointer fetches from memory.
*/
// Functional notes
// - X and Y are one bit each, decoded with the indirect flag
// - A selected index register adds to the offset built so far
// - Base select 00 procedure, 01 stack, 10 link, 11 auxiliary
// - Displacement is a 16-bit offset, alone or summed
// - Direct address is base register plus displacement
// - Indexed address is base plus index plus displacement
// - Outside I mode, opcode bits 1101 disable indexing
// - Short indirection reads the word at displacement in procedure segment
// - Multi-level modes follow the indirect chain to its end
// - Long pointer extension flag: 0 gives 32 bits, 1 gives 48 bits
// - Long pointer with fault flag set raises a pointer fault
// - A 48-bit pointer carries a bit number within the offset
// - Pre-indexed: index, base, displacement form indirect address
// - Post-indexed: base plus displacement, resolve, then add index
// - Register-relative segment is source register bits 5 to 16
// - Register-relative offset is displacement plus source bits 17 to 32
// - Short V form reaches 256 stack/link words, 224 around procedure
// - Long V form reaches four segments; pointers reach 4096 segments
// - Base register: ring bits 2-3, segment 5-16, offset 17-32
// - Ring is the highest of program counter, base and pointers
// - A general register used as index adds only bits 1 to 16
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

// Register word addresses
`define EAG_REG_PROC_BASE 4'h0
`define EAG_REG_STACK_BASE 4'h1
`define EAG_REG_LINK_BASE 4'h2
`define EAG_REG_AUX_BASE 4'h3
`define EAG_REG_INDEX_X 4'h4
`define EAG_REG_INDEX_Y 4'h5
`define EAG_REG_CTRL 4'h6
`define EAG_REG_STATUS 4'h7
`define EAG_NUM_GPREGS 6

// Reset values
`define EAG_CTRL_RESET 3'h2
`define EAG_REG_RESET 32'h0000_0000

// Control fields: mode in [1:0], chain enable in [2]
`define EAG_CTRL_MODE_LSB 0
`define EAG_CTRL_CHAIN_BIT 2

// Base register and pointer fields (bit 1 of the word is the msb)
`define EAG_BR_RING_MSB 30
`define EAG_BR_RING_LSB 29
`define EAG_BR_SEG_MSB 27
`define EAG_BR_SEG_LSB 16
`define EAG_BR_OFF_MSB 15
`define EAG_PTR_FAULT_BIT 47
`define EAG_PTR_RING_MSB 46
`define EAG_PTR_RING_LSB 45
`define EAG_PTR_EXT_BIT 44
`define EAG_PTR_SEG_MSB 43
`define EAG_PTR_SEG_LSB 32
`define EAG_PTR_OFF_MSB 31
`define EAG_PTR_OFF_LSB 16
`define EAG_PTR_BITNO_MSB 15
`define EAG_PTR_BITNO_LSB 12
`define EAG_SHORT_IND_BIT 15

// Opcode pattern that forbids indexing, and short-form reach limits
`define EAG_NOINDEX_OP 4'hd
`define EAG_SHORT_BASE_REACH 16'h0100
`define EAG_SHORT_PC_REACH 9'h0e0

`endif

// File: hw/eag_pkg.sv
/*
 Types of the effective address generator. Assumes eag_defs.svh for the
 numeric constants.
*/
package eag_pkg;

   // Addressing modes held in the control register
   typedef enum logic [1:0] {
      EAG_MODE_S = 2'b00,
      EAG_MODE_R = 2'b01,
      EAG_MODE_V = 2'b10,
      EAG_MODE_I = 2'b11
   } eag_mode_t;

   // Sequencer states
   typedef enum logic [1:0] {
      EAG_ST_IDLE = 2'b00,
      EAG_ST_FETCH = 2'b01
   } eag_state_t;

endpackage

// File: hw/eag_offset_sum.sv
/*
 Three-term offset adder. Assumes operands are already 16-bit offsets;
 the carry out is dropped so a sum stays inside its segment.
*/
`timescale 1ns/1ps
module eag_offset_sum (
   input wire logic [15:0] base_off, // Offset from base or source register
   input wire logic [15:0] index_off, // Index contribution or zero
   input wire logic [15:0] offset_constant_off, // Displacement
   output logic [15:0] sum_off // Wrapped sum
);
   // ------------------------------------------------------------
   // Sum
   // ------------------------------------------------------------
   // Wider intermediate kept only to make the truncation explicit
   logic [17:0] wide;
   always_comb begin
      wide = {2'b00, base_off} + {2'b00, index_off} + {2'b00, offset_constant_off};
      sum_off = wide[15:0];
   end
endmodule

// File: hw/eag_regfile.sv
/*
 Base and index register file with the register port read path. Assumes
 the top supplies the control and status words for their read slots.
*/
`timescale 1ns/1ps
`include "eag_defs.svh"
module eag_regfile (
   input wire logic sys_clk, // Processor clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [3:0] reg_addr, // Word address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [31:0] ctrl_word, // Control register image
   input wire logic [31:0] status_word, // Status image
   output logic [5:0][31:0] regs, // All base and index registers
   output logic [31:0] reg_rdata // Read data, cycle after strobe
);
   typedef struct packed {
      logic [5:0][31:0] regs;
      logic [31:0] rdata;
   } eag_rf_state_t;
   eag_rf_state_t rf_q, rf_d;

   // ------------------------------------------------------------
   // Write and read
   // ------------------------------------------------------------
   // Unmapped reads return zero; read data last only one cycle
   always_comb begin
      rf_d = rf_q;
      rf_d.rdata = 32'h0000_0000;
      if (reg_wr && reg_addr < 4'h6) begin
         rf_d.regs[reg_addr[2:0]] = reg_wdata;
      end
      if (reg_rd) begin
         if (reg_addr < 4'h6) begin
            rf_d.rdata = rf_q.regs[reg_addr[2:0]];
         end else if (reg_addr == `EAG_REG_CTRL) begin
            rf_d.rdata = ctrl_word;
         end else if (reg_addr == `EAG_REG_STATUS) begin
            rf_d.rdata = status_word;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rf_q <= '0;
      end else begin
         rf_q <= rf_d;
      end
   end

   assign regs = rf_q.regs;
   assign reg_rdata = rf_q.rdata;
endmodule

// File: hw/eag_top.sv
/*
 Effective address generator: forms segment, offset, ring and bit number of
 a memory reference by direct, indexed, indirect, pre/post-indexed indirect
 or register-relative means. Assumes the decoder holds the request fields
 while req_valid is high and the memory unit answers each fetch with one
 mem_ack pulse on the same clock.
*/
`timescale 1ns/1ps
`include "eag_defs.svh"
module eag_top (
   input wire logic sys_clk, // Processor clock, 40 MHz
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [3:0] reg_addr, // Register word address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [31:0] reg_rdata, // Register read data
   input wire logic req_valid, // Decoder offers a reference
   input wire logic req_ind, // Indirect flag
   input wire logic req_x, // X index select
   input wire logic req_y, // Y index select
   input wire logic [3:0] req_op, // Opcode bits 3 to 6
   input wire logic [1:0] base_select_field, // Base register choice
   input wire logic [15:0] offset_constant, // Displacement
   input wire logic req_short, // 16-bit instruction form
   input wire logic register_relative_mode, // Source register as base
   input wire logic [31:0] req_src_reg, // Named source general register
   input wire logic [31:0] req_gr_index, // General register used as index
   input wire logic [31:0] req_pc, // Program counter: ring, segment, offset
   output logic busy, // Request in progress
   output logic mem_req, // Pointer fetch request
   output logic [27:0] mem_addr, // Pointer word address, segment and offset
   input wire logic mem_ack, // Fetch data valid
   input wire logic [47:0] mem_rdata, // Fetched pointer, msb first
   output logic ea_valid, // Effective address ready, one cycle
   output logic [1:0] ea_ring, // Effective ring
   output logic [11:0] ea_seg, // Effective segment
   output logic [15:0] ea_off, // Effective offset
   output logic [3:0] ea_bitno, // Bit number of a 48-bit pointer
   output logic ea_bitno_valid, // Bit number present
   output logic ptr_fault, // Pointer fault, one cycle
   output logic [27:0] fault_addr, // Address of the faulting pointer
   output logic reach_err // Short form out of reach, with ea_valid
);
   import eag_pkg::*;

   typedef struct packed {
      eag_state_t st;
      logic [2:0] ctrl;
      logic is_long;
      logic post;
      logic [15:0] post_idx;
      logic [1:0] ring;
      logic mem_req;
      logic [27:0] mem_addr;
      logic ea_valid;
      logic [1:0] ea_ring;
      logic [11:0] ea_seg;
      logic [15:0] ea_off;
      logic [3:0] ea_bitno;
      logic ea_bitv;
      logic fault;
      logic [27:0] fault_addr;
      logic reach_err;
   } eag_top_state_t;
   eag_top_state_t s_q, s_d;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Higher of two ring numbers
   function automatic logic [1:0] ring_max(input logic [1:0] a, input logic [1:0] b);
      ring_max = (a > b) ? a : b;
   endfunction

   // Plain 16-bit wrap-around add
   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] w;
      w = {1'b0, a} + {1'b0, b};
      add16 = w[15:0];
   endfunction

   logic [5:0][31:0] regs;
   logic [31:0] base_word;
   logic [15:0] idx_val;
   logic [15:0] offset_constant_eff;
   logic [15:0] base_off;
   logic [15:0] pre_idx;
   logic [15:0] sum_off;
   logic [15:0] pc_rel_off;
   logic [8:0] pc_offset_constant;
   logic [11:0] base_seg;
   logic [1:0] base_ring;
   logic idx_ok;
   logic use_idx;
   logic idx_is_y;
   logic short_v;
   logic long_form;
   logic accept;
   eag_mode_t mode;

   // ------------------------------------------------------------
   // Register file and adder
   // ------------------------------------------------------------
   eag_regfile u_regfile (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .ctrl_word({29'h0000_0000, s_q.ctrl}),
      .status_word({26'h000_0000, s_q.reach_err, s_q.fault, s_q.is_long, s_q.post,
                    s_q.st}),
      .regs(regs),
      .reg_rdata(reg_rdata)
   );

   eag_offset_sum u_sum (
      .base_off(base_off),
      .index_off(pre_idx),
      .offset_constant_off(offset_constant_eff),
      .sum_off(sum_off)
   );

   // ------------------------------------------------------------
   // Field decode of the request
   // ------------------------------------------------------------
   // Index choice: without indirection X wins over Y; with it X means
   // pre-indexing and Y post-indexing
   always_comb begin
      mode = eag_mode_t'(s_q.ctrl[1:0]);
      accept = req_valid && (s_q.st == EAG_ST_IDLE);
      base_word = regs[base_select_field];
      base_ring = base_word[`EAG_BR_RING_MSB:`EAG_BR_RING_LSB];
      base_seg = base_word[`EAG_BR_SEG_MSB:`EAG_BR_SEG_LSB];
      base_off = base_word[`EAG_BR_OFF_MSB:0];
      idx_ok = !((mode != EAG_MODE_I) && (req_op == `EAG_NOINDEX_OP));
      use_idx = (req_x || req_y) && idx_ok;
      idx_is_y = req_y && !req_x;
      // I mode indexes with a general register, high half only
      if (mode == EAG_MODE_I) begin
         idx_val = req_gr_index[31:16];
      end else if (idx_is_y) begin
         idx_val = regs[`EAG_REG_INDEX_Y][15:0];
      end else begin
         idx_val = regs[`EAG_REG_INDEX_X][15:0];
      end
      short_v = req_short && (mode == EAG_MODE_V);
      long_form = !req_short && ((mode == EAG_MODE_V) || (mode == EAG_MODE_I));
      offset_constant_eff = offset_constant;
      pc_offset_constant = offset_constant[8:0];
      pc_rel_off = add16(req_pc[15:0], {{7{pc_offset_constant[8]}}, pc_offset_constant});
      // Register-relative takes the source register in place of the base
      if (register_relative_mode) begin
         base_off = req_src_reg[15:0];
      end else if (short_v) begin
         offset_constant_eff = {8'h00, offset_constant[7:0]};
      end
      // Index joins the sum for plain indexed and pre-indexed forms only
      if (use_idx && !(req_ind && idx_is_y) && !register_relative_mode) begin
         pre_idx = idx_val;
      end else begin
         pre_idx = 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // One cycle for direct forms; indirect forms wait on memory and may loop
   // on a short chain. Requests are ignored while busy is high.
   always_comb begin
      s_d = s_q;
      s_d.ea_valid = 1'b0;
      s_d.fault = 1'b0;
      if (reg_wr && reg_addr == `EAG_REG_CTRL) begin
         s_d.ctrl = reg_wdata[2:0];
      end
      case (s_q.st)
         EAG_ST_IDLE: begin
            if (accept) begin
               s_d.reach_err = 1'b0;
               s_d.ea_bitv = 1'b0;
               s_d.ea_bitno = 4'h0;
               s_d.post = req_ind && use_idx && idx_is_y && !register_relative_mode;
               s_d.post_idx = idx_val;
               s_d.is_long = long_form;
               s_d.ring = ring_max(req_pc[`EAG_BR_RING_MSB:`EAG_BR_RING_LSB], base_ring);
               if (register_relative_mode) begin
                  s_d.ea_seg = req_src_reg[`EAG_BR_SEG_MSB:`EAG_BR_SEG_LSB];
                  s_d.ea_off = sum_off;
                  s_d.ea_ring = ring_max(req_pc[`EAG_BR_RING_MSB:`EAG_BR_RING_LSB],
                                         req_src_reg[`EAG_BR_RING_MSB:`EAG_BR_RING_LSB]);
                  s_d.ea_valid = 1'b1;
               end else if (short_v && base_select_field == 2'b00) begin
                  // Procedure-relative short form: signed 9-bit step from PC
                  s_d.ea_seg = req_pc[`EAG_BR_SEG_MSB:`EAG_BR_SEG_LSB];
                  s_d.ea_off = pc_rel_off;
                  s_d.ea_ring = s_d.ring;
                  s_d.reach_err = pc_offset_constant[8] ? (pc_offset_constant < (~`EAG_SHORT_PC_REACH + 9'h001))
                                             : (pc_offset_constant > `EAG_SHORT_PC_REACH);
                  s_d.ea_valid = 1'b1;
               end else if (!req_ind) begin
                  s_d.ea_seg = base_seg;
                  s_d.ea_off = sum_off;
                  s_d.ea_ring = s_d.ring;
                  s_d.ea_valid = 1'b1;
               end else begin
                  s_d.st = EAG_ST_FETCH;
                  s_d.mem_req = 1'b1;
                  if (long_form) begin
                     s_d.mem_addr = {base_seg, sum_off};
                  end else begin
                     // Short pointer sits in the procedure segment
                     s_d.mem_addr = {req_pc[`EAG_BR_SEG_MSB:`EAG_BR_SEG_LSB],
                                     add16(offset_constant, pre_idx)};
                  end
               end
            end
         end
         EAG_ST_FETCH: begin
            if (mem_ack) begin
               s_d.mem_req = 1'b0;
               s_d.st = EAG_ST_IDLE;
               if (s_q.is_long) begin
                  if (mem_rdata[`EAG_PTR_FAULT_BIT]) begin
                     // Faulting pointer: no address, report where it lives
                     s_d.fault = 1'b1;
                     s_d.fault_addr = s_q.mem_addr;
                  end else begin
                     s_d.ea_ring = ring_max(s_q.ring,
                        mem_rdata[`EAG_PTR_RING_MSB:`EAG_PTR_RING_LSB]);
                     s_d.ea_seg = mem_rdata[`EAG_PTR_SEG_MSB:`EAG_PTR_SEG_LSB];
                     s_d.ea_off = mem_rdata[`EAG_PTR_OFF_MSB:`EAG_PTR_OFF_LSB];
                     s_d.ea_bitv = mem_rdata[`EAG_PTR_EXT_BIT];
                     s_d.ea_bitno = mem_rdata[`EAG_PTR_EXT_BIT] ?
                        mem_rdata[`EAG_PTR_BITNO_MSB:`EAG_PTR_BITNO_LSB] : 4'h0;
                     if (s_q.post) begin
                        s_d.ea_off = add16(s_d.ea_off, s_q.post_idx);
                     end
                     s_d.ea_valid = 1'b1;
                  end
               end else if (s_q.ctrl[`EAG_CTRL_CHAIN_BIT] &&
                            mem_rdata[32 + `EAG_SHORT_IND_BIT]) begin
                  // Another link in the chain: fetch again, stay busy
                  s_d.st = EAG_ST_FETCH;
                  s_d.mem_req = 1'b1;
                  s_d.mem_addr = {s_q.mem_addr[27:16], 1'b0, mem_rdata[46:32]};
               end else begin
                  s_d.ea_seg = s_q.mem_addr[27:16];
                  s_d.ea_ring = s_q.ring;
                  s_d.ea_off = s_q.ctrl[`EAG_CTRL_CHAIN_BIT] ?
                     {1'b0, mem_rdata[46:32]} : mem_rdata[47:32];
                  if (s_q.post) begin
                     s_d.ea_off = add16(s_d.ea_off, s_q.post_idx);
                  end
                  s_d.ea_valid = 1'b1;
               end
            end
         end
         default: begin
            s_d.st = EAG_ST_IDLE;
            s_d.mem_req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.ctrl <= `EAG_CTRL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Fetch is the only state with bit 0 set, so busy is a plain flop bit
   assign busy = s_q.st[0];
   assign mem_req = s_q.mem_req;
   assign mem_addr = s_q.mem_addr;
   assign ea_valid = s_q.ea_valid;
   assign ea_ring = s_q.ea_ring;
   assign ea_seg = s_q.ea_seg;
   assign ea_off = s_q.ea_off;
   assign ea_bitno = s_q.ea_bitno;
   assign ea_bitno_valid = s_q.ea_bitv;
   assign ptr_fault = s_q.fault;
   assign fault_addr = s_q.fault_addr;
   assign reach_err = s_q.reach_err;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic direct_acc;
   logic [15:0] chk_direct;
   logic [15:0] chk_indexed;
   logic [11:0] chk_src_seg;
   logic [11:0] chk_sb_seg;
   always_comb begin
      direct_acc = accept && !req_ind && !register_relative_mode && !short_v;
      chk_direct = add16(base_off, offset_constant);
      chk_indexed = add16(chk_direct, idx_val);
      chk_src_seg = req_src_reg[27:16];
      chk_sb_seg = regs[`EAG_REG_STACK_BASE][27:16];
   end

   property p_direct;
      @(posedge sys_clk) disable iff (sys_rst)
      (direct_acc && !use_idx) |=> (ea_valid && ea_off == $past(chk_direct));
   endproperty
   a_direct: assert property (p_direct) else $error("direct offset wrong");

   property p_indexed;
      @(posedge sys_clk) disable iff (sys_rst)
      (direct_acc && use_idx) |=> (ea_off == $past(chk_indexed));
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed offset wrong");

   property p_noindex;
      @(posedge sys_clk) disable iff (sys_rst)
      (mode != EAG_MODE_I && req_op == `EAG_NOINDEX_OP) |-> !use_idx;
   endproperty
   a_noindex: assert property (p_noindex) else $error("forbidden indexing");

   property p_stack_base;
      @(posedge sys_clk) disable iff (sys_rst)
      (direct_acc && base_select_field == 2'b01) |=> (ea_seg == $past(chk_sb_seg));
   endproperty
   a_stack_base: assert property (p_stack_base) else $error("base select wrong");

   property p_grr_seg;
      @(posedge sys_clk) disable iff (sys_rst)
      (accept && register_relative_mode) |=> (ea_valid && ea_seg == $past(chk_src_seg));
   endproperty
   a_grr_seg: assert property (p_grr_seg) else $error("relative segment wrong");

   property p_fault;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_q.st == EAG_ST_FETCH && mem_ack && s_q.is_long && mem_rdata[47])
         |=> (ptr_fault && !ea_valid && !mem_req);
   endproperty
   a_fault: assert property (p_fault) else $error("pointer fault missed");

   property p_fault_addr;
      @(posedge sys_clk) disable iff (sys_rst)
      ptr_fault |-> (fault_addr == $past(mem_addr) && !busy);
   endproperty
   a_fault_addr: assert property (p_fault_addr) else $error("fault address wrong");

   property p_ext;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_q.st == EAG_ST_FETCH && mem_ack && s_q.is_long && !mem_rdata[47])
         |=> (ea_valid && ea_bitno_valid == $past(mem_rdata[44]));
   endproperty
   a_ext: assert property (p_ext) else $error("pointer size wrong");

   property p_ring;
      @(posedge sys_clk) disable iff (sys_rst)
      (ea_valid && !$past(register_relative_mode)) |-> (ea_ring >= s_q.ring);
   endproperty
   a_ring: assert property (p_ring) else $error("ring lower than source");

   c_direct: cover property (@(posedge sys_clk) direct_acc ##1 ea_valid);
   c_fault: cover property (@(posedge sys_clk) ptr_fault);
   c_chain: cover property (@(posedge sys_clk) mem_ack && s_d.st == EAG_ST_FETCH);
   c_post: cover property (@(posedge sys_clk) ea_valid && $past(s_q.post));
endmodule

// File: bench/eag_mem_model.sv
/*
 Memory unit model: returns one word per pointer fetch.
 Assumes mem_req stays high until the ack edge.
*/
`timescale 1ns/1ps
module eag_mem_model (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic mem_req, // Fetch request
   input wire logic [47:0] ptr_word, // Word to return
   input wire logic [1:0] lat, // Wait cycles
   output logic mem_ack, // Data valid
   output logic [47:0] mem_rdata // Junk outside ack
);
   logic [1:0] cnt_q;
   // ------
   // Answer
   // ------
   // Idle data toggles so a stale word is never mistaken for a fresh one
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         mem_ack <= 1'b0;
         mem_rdata <= 48'h0000_0000_0000;
      end else if (mem_ack || !mem_req || cnt_q != lat) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else begin
         mem_ack <= 1'b1;
         mem_rdata <= ptr_word;
      end
      cnt_q <= (sys_rst || !mem_req || mem_ack) ? 2'h0 : cnt_q + 2'h1;
   end
endmodule

// File: bench/testbench.sv
/*
 Scenario bench of the address generator.
 Assumes eag_mem_model answers the pointer fetches.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0, i_q = 0, x_q = 0;
   logic y_q = 0, regrel = 0, mem_ack, saw_ea, saw_flt, ea_valid, ptr_fault, mem_req, bv;
   logic sh = 0, bsy, bsy_q, rerr;
   logic [3:0] reg_addr = 4'h0, op_q = 4'h0, bitno;
   logic [1:0] bs_q = 2'h0, lat = 2'h0, ring;
   logic [31:0] reg_wdata = 32'h0000_0000, rd, reg_rdata, gri = 32'h0000_0000;
   logic [15:0] d_q = 16'h0000, off;
   logic [47:0] word = 48'h0000_0000_0000, mem_rdata;
   logic [27:0] mem_addr, faddr;
   logic [11:0] seg;
   int errors = 0, checks = 0;
   eag_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
      .req_ind(i_q), .req_x(x_q), .req_y(y_q), .req_op(op_q), .base_select_field(bs_q),
      .offset_constant(d_q), .req_short(sh), .register_relative_mode(regrel),
      .req_src_reg(32'h4777_fff0), .req_gr_index(gri), .req_pc(32'h20ab_0000),
      .busy(bsy), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .ea_valid(ea_valid), .ea_ring(ring), .ea_seg(seg), .ea_off(off),
      .ea_bitno(bitno), .ea_bitno_valid(bv), .ptr_fault(ptr_fault), .fault_addr(faddr),
      .reach_err(rerr));
   eag_mem_model u_mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_req(mem_req),
      .ptr_word(word), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // -----------
   // Bus helpers
   // -----------
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   function logic [31:0] basew(input logic [1:0] k);
      return {1'b0, k, 1'b0, 12'h100 + {10'h000, k}, 16'hf000 + {14'h0000, k}};
   endfunction
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rdr(input logic [3:0] a);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Waits a bounded time so a lost answer shows as a mismatch, not a hang
   task req(input logic i, x, y, input logic [3:0] op, input logic [1:0] bs,
      input logic [15:0] d);
      @(posedge sys_clk);
      {req_valid, i_q, x_q, y_q, op_q, bs_q, d_q} <= {1'b1, i, x, y, op, bs, d};
      @(posedge sys_clk);
      req_valid <= 1'b0;
      #1 bsy_q = bsy;
      repeat (12) begin
         if (ea_valid || ptr_fault) break;
         @(posedge sys_clk);
         #1;
      end
      {saw_ea, saw_flt} = {ea_valid, ptr_fault};
      `CHK(saw_ea | saw_flt, 1'b1)
   endtask
   // ---------
   // Scenarios
   // ---------
   task t_regs;
      rdr(4'h6);
      `CHK(rd, 32'h0000_0002)
      rdr(4'h9);
      `CHK(rd, 32'h0000_0000)
      for (int k = 0; k < 4; k++) wr(4'(k), basew(2'(k)));
      wr(4'h4, 32'h0000_0050);
      wr(4'h5, 32'h0000_0007);
      rdr(4'h3);
      `CHK(rd, basew(2'h3))
      $display("test regs done");
   endtask
   task t_direct;
      for (int k = 0; k < 4; k++) begin
         req(0, 0, 0, 4'h0, 2'(k), 16'h1234);
         `CHK(seg, 12'h100 + 12'(k))
         `CHK(off, 16'h0234 + 16'(k))
         `CHK(ring, k > 1 ? 2'(k) : 2'h1)
      end
      req(0, 1, 0, 4'h0, 2'h1, 16'h1234);
      `CHK(off, 16'h0285)
      req(0, 1, 0, 4'hd, 2'h1, 16'h1234);
      `CHK(off, 16'h0235)
      req(0, 0, 1, 4'h0, 2'h1, 16'h1234);
      `CHK(off, 16'h023c)
      $display("test direct done");
   endtask
   // Slow fetch, 48-bit pointer, post-indexed by Y; then a faulting pointer
   task t_ind;
      {word, lat} = {48'h73c5_8000_9000, 2'h3};
      req(1, 0, 1, 4'h0, 2'h2, 16'h0010);
      `CHK(seg, 12'h3c5)
      `CHK(off, 16'h8007)
      `CHK(ring, 2'h3)
      `CHK({bv, bitno}, 5'h19)
      `CHK({bsy_q, mem_addr}, 29'h1102_f012)
      {word, lat} = {48'h8123_4567_0000, 2'h0};
      req(1, 0, 0, 4'h0, 2'h2, 16'h0010);
      `CHK({saw_flt, saw_ea}, 2'h2)
      `CHK(faddr, 28'h102_f012)
      $display("test indirect done");
   endtask
   // Short V forms: two-link chain, PC-relative reach, base-relative byte
   task t_short;
      wr(4'h6, 32'h0000_0006);
      sh <= 1'b1;
      {word, lat} = {48'h8042_0000_0000, 2'h0};
      fork
         req(1, 0, 0, 4'h0, 2'h1, 16'h0030);
         begin
            @(posedge mem_ack);
            word[47] = 1'b0;
         end
      join
      `CHK({seg, off}, 28'h0ab_0042)
      `CHK(mem_addr, 28'h0ab_0042)
      req(0, 0, 0, 4'h0, 2'h0, 16'h01f0);
      `CHK({rerr, off}, 17'h0_fff0)
      req(0, 0, 0, 4'h0, 2'h0, 16'h0100);
      `CHK({rerr, off}, 17'h1_ff00)
      req(0, 0, 0, 4'h0, 2'h1, 16'h0123);
      `CHK(off, 16'hf024)
      $display("test short done");
   endtask
   task t_grr;
      wr(4'h6, 32'h0000_0003);
      regrel <= 1'b1;
      req(0, 0, 0, 4'h0, 2'h0, 16'h0020);
      `CHK(seg, 12'h777)
      `CHK({ring, off}, 18'h2_0010)
      @(posedge sys_clk);
      {regrel, gri} <= {1'b0, 32'h0003_0000};
      req(0, 1, 0, 4'hd, 2'h1, 16'h1234);
      `CHK(off, 16'h0238)
      $display("test relative done");
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_direct;
      t_ind;
      t_short;
      t_grr;
      end_of_test;
   end
   // Tests take well under 400 cycles
   initial begin
      #50000;
      errors++;
      end_of_test;
   end
endmodule
